/* File: hw/twe_pkg.sv */
// constants and types for the two-wire serial memory slave
// assumes: one core clock domain plus the master's serial clock domain
//
// Summary of operation
// - data changes only while clock low
// - falling data with clock high starts
// - rising data with clock high stops
// - stop after read enters standby
// - eight bits, then receiver acknowledges ninth
// - matching address acknowledged, then read/write
// - every written byte acknowledged
// - read: send eight, release, sample acknowledge
// - no acknowledge ends read output
// - top four address bits match type code
// - next three bits match select straps
// - lowest address bit selects read/write
// - word address seven bits, top ignored
// - stop after data starts internal write
// - internal write self-timed, five milliseconds
// - busy writing: no acknowledge, no response
// - page write takes up to four bytes
// - page bytes bump only low two bits
// - extra page bytes wrap and overwrite
// - address counter holds last plus one
// - sequential read wraps full address space
// - busy device ignores acknowledge polling

package twe_pkg;

	// ************************************************************
	// memory shape and timing
	// ************************************************************
	localparam int TWE_ADDR_W        = 7;     // 128 words
	localparam int TWE_PAGE_W        = 2;     // four-byte page
	localparam int TWE_TIMER_W       = 24;    // write timer width
	localparam int TWE_WRITE_TIME_US = 5000;  // internal write, 5 ms
	localparam int TWE_CORE_CLK_MHZ  = 50;    // core clock rate
	localparam int TWE_WRITE_CYCLES  = TWE_WRITE_TIME_US * TWE_CORE_CLK_MHZ;

	// ************************************************************
	// slave address byte layout and bit slots
	// ************************************************************
	localparam int TWE_SA_TYPE_LSB = 4;       // device type code field
	localparam int TWE_SA_SEL_LSB  = 1;       // strap select field
	localparam int TWE_SA_RW_BIT   = 0;       // one means read
	localparam logic [3:0] TWE_LAST_BIT = 4'h7; // eighth bit of a byte
	localparam logic [3:0] TWE_ACK_SLOT = 4'h8; // ninth clock
	localparam logic [3:0] TWE_TYPE_DEF = 4'h5; // arbitrary neutral value

	// ************************************************************
	// link engine states and state records
	// ************************************************************
	typedef enum logic [2:0] {
		TWE_IDLE, TWE_SADDR, TWE_WORD, TWE_DATA, TWE_READ, TWE_IGNORE
	} twe_state_t;

	typedef struct packed {
		twe_state_t      state;   // protocol state
		logic [3:0]      cnt;     // bit slot within byte
		logic [7:0]      shift;   // receive shifter
		logic [7:0]      tx;      // transmit shifter
		logic [6:0]      addr;    // word address counter
		logic [3:0][7:0] page;    // page write buffer
		logic [3:0]      valid;   // page slots filled
		logic            wr_tog;  // flips once per new write
		logic            oe;      // pulling data line low
		logic            out;     // data output level
		logic            busy_m;  // busy synchroniser, first
		logic            busy_s;  // busy synchroniser, second
		logic [2:0]      strap_m; // strap synchroniser, first
		logic [2:0]      strap_s; // strap synchroniser, second
	} twe_link_t;

	typedef struct packed {
		logic                   scl_m, scl_s, scl_p; // clock level sync
		logic                   sda_m, sda_s, sda_p; // data level sync
		logic                   tog_m, tog_s;        // write toggle sync
		logic                   tog_seen;            // last committed
		logic                   busy;                // internal write
		logic                   standby;             // low-power state
		logic [TWE_TIMER_W-1:0] timer;               // write countdown
	} twe_core_t;

endpackage

/* File: hw/twe_slave.sv */
// two-wire serial memory slave: protocol engine and storage
// assumes: sda_i is the resolved wire level, scl_clk is the bus clock
// and may stand still between frames; core_clk runs freely
`timescale 1ns/1ps

module twe_slave import twe_pkg::*; #(
	parameter int unsigned WRITE_CYCLES = TWE_WRITE_CYCLES, // write time
	parameter logic [3:0]  DEVICE_TYPE  = TWE_TYPE_DEF      // arbitrary
) (
	// core clock and reset
	input  wire logic core_clk,
	input  wire logic reset,
	// serial bus
	input  wire logic scl_clk,
	input  wire logic sda_i,
	output logic      sda_o,
	output logic      sda_oe,
	// select straps
	input  wire logic select_strap_bit0,
	input  wire logic select_strap_bit1,
	input  wire logic select_strap_bit2,
	// status
	output logic      standby,
	output logic      write_busy
);

	// ************************************************************
	// elaboration checks
	// ************************************************************
	if (WRITE_CYCLES < 1 || WRITE_CYCLES >= (1 << TWE_TIMER_W)) begin : g_chk
		$error("write cycle count does not fit the timer");
	end

	// ************************************************************
	// storage and state
	// ************************************************************
	logic [7:0]  mem [0:(1<<TWE_ADDR_W)-1]; // nonvolatile array model
	twe_link_t   l_q, l_d;                  // link domain state
	twe_core_t   c_q, c_d;                  // core domain state
	logic        sda_hi_q;                  // data at clock rise
	logic        rst_m_q, rst_s_q;          // reset into link domain
	logic        link_rst;                  // link domain reset
	logic        start_w, stop_w;           // conditions at clock fall
	logic [7:0]  byte_w;                    // byte with newest bit
	logic        match_w;                   // address compare result
	logic [7:0]  rd_w;                      // word at address counter
	logic        c_start, c_stop;           // conditions seen by core
	logic        commit_w;                  // stop arms a write

	// address compare: type code, then straps
	function automatic logic twe_match(input logic [7:0] b,
	                                   input logic [2:0] s);
		twe_match = (b[TWE_SA_TYPE_LSB +: 4] == DEVICE_TYPE) &&
		            (b[TWE_SA_SEL_LSB +: 3] == s);
	endfunction

	// ************************************************************
	// link domain: reset crossing and rising-edge sampler
	// ************************************************************
	// reset reaches the link only while the bus clock runs; a start
	// condition puts the engine in a known state regardless
	always_ff @(negedge scl_clk) begin
		rst_m_q <= reset;
		rst_s_q <= rst_m_q;
	end
	assign link_rst = rst_s_q;

	// data bit taken where the bus defines it valid
	always_ff @(posedge scl_clk) begin
		if (link_rst) begin
			sda_hi_q <= 1'b1;
		end else begin
			sda_hi_q <= sda_i;
		end
	end

	// ************************************************************
	// link domain: protocol engine, stepped at each clock fall
	// ************************************************************
	// the array is only written while busy, and the engine refuses
	// all requests while busy, so this read never sees it change
	assign rd_w    = mem[l_q.addr];
	// data level at clock rise against level at fall: a change in
	// between can only be a start or stop
	// limitation: the engine only looks at a clock fall, so a stop
	// and a start inside one clock-high phase cancel out here; the
	// master must let the clock fall once between them (that fall
	// then reports the stop), while the core side watches the wire
	// levels and sees both regardless
	assign start_w = sda_hi_q & ~sda_i;
	assign stop_w  = ~sda_hi_q & sda_i;
	assign byte_w  = {l_q.shift[6:0], sda_hi_q};
	assign match_w = twe_match(byte_w, l_q.strap_s);

	always_comb begin
		l_d         = l_q;
		l_d.out     = 1'b0;
		l_d.busy_m  = c_q.busy;
		l_d.busy_s  = l_q.busy_m;
		l_d.strap_m = {select_strap_bit2, select_strap_bit1,
		               select_strap_bit0};
		l_d.strap_s = l_q.strap_m;
		if (start_w) begin
			// abort whatever was running
			l_d.state = TWE_SADDR;
			l_d.cnt   = 4'h0;
			l_d.oe    = 1'b0;
		end else if (stop_w) begin
			// end of frame, line released
			l_d.state = TWE_IDLE;
			l_d.oe    = 1'b0;
		end else begin
			case (l_q.state)
			TWE_IDLE, TWE_IGNORE: begin
				// only a start wakes the engine
				l_d.oe = 1'b0;
			end
			TWE_SADDR: begin
				if (l_q.cnt == TWE_ACK_SLOT) begin
					l_d.cnt = 4'h0;
					if (l_q.shift[TWE_SA_RW_BIT]) begin
						// read: load and drive first bit
						l_d.state = TWE_READ;
						l_d.tx    = rd_w;
						l_d.addr  = l_q.addr + 7'h01;
						l_d.oe    = ~rd_w[7];
					end else begin
						// write: fresh page buffer
						l_d.state = TWE_WORD;
						l_d.valid = 4'h0;
						l_d.oe    = 1'b0;
					end
				end else begin
					l_d.shift = byte_w;
					l_d.cnt   = l_q.cnt + 4'h1;
					if (l_q.cnt == TWE_LAST_BIT) begin
						if (match_w && !l_q.busy_s) begin
							l_d.oe = 1'b1;
						end else begin
							// no match, or write still running
							l_d.state = TWE_IGNORE;
						end
					end
				end
			end
			TWE_WORD: begin
				if (l_q.cnt == TWE_ACK_SLOT) begin
					l_d.state = TWE_DATA;
					l_d.cnt   = 4'h0;
					l_d.oe    = 1'b0;
				end else begin
					l_d.shift = byte_w;
					l_d.cnt   = l_q.cnt + 4'h1;
					if (l_q.cnt == TWE_LAST_BIT) begin
						// top bit of word address ignored
						l_d.addr = byte_w[6:0];
						l_d.oe   = 1'b1;
					end
				end
			end
			TWE_DATA: begin
				if (l_q.cnt == TWE_ACK_SLOT) begin
					l_d.cnt = 4'h0;
					l_d.oe  = 1'b0;
				end else begin
					l_d.shift = byte_w;
					l_d.cnt   = l_q.cnt + 4'h1;
					if (l_q.cnt == TWE_LAST_BIT) begin
						// slot by low bits: a fifth byte overwrites the first
						l_d.page[l_q.addr[1:0]]  = byte_w;
						l_d.valid[l_q.addr[1:0]] = 1'b1;
						if (l_q.valid == 4'h0) begin
							l_d.wr_tog = ~l_q.wr_tog;
						end
						l_d.addr = {l_q.addr[6:2],
						            l_q.addr[1:0] + 2'h1};
						l_d.oe   = 1'b1;
					end
				end
			end
			TWE_READ: begin
				if (l_q.cnt == TWE_ACK_SLOT) begin
					if (!sda_hi_q) begin
						// acknowledged: next word, wraps at top
						l_d.cnt  = 4'h0;
						l_d.tx   = rd_w;
						l_d.addr = l_q.addr + 7'h01;
						l_d.oe   = ~rd_w[7];
					end else begin
						l_d.state = TWE_IGNORE;
						l_d.oe    = 1'b0;
					end
				end else if (l_q.cnt == TWE_LAST_BIT) begin
					// eight sent: release for the master's answer
					l_d.cnt = TWE_ACK_SLOT;
					l_d.oe  = 1'b0;
				end else begin
					l_d.cnt = l_q.cnt + 4'h1;
					l_d.tx  = {l_q.tx[6:0], 1'b0};
					l_d.oe  = ~l_q.tx[6];
				end
			end
			default: begin
				l_d.state = TWE_IDLE;
				l_d.oe    = 1'b0;
			end
			endcase
		end
	end

	// link state register; drive changes only at clock fall
	always_ff @(negedge scl_clk) begin
		if (link_rst) begin
			l_q <= '0;
		end else begin
			l_q <= l_d;
		end
	end

	// ************************************************************
	// core domain: bus watch, write timer, standby
	// ************************************************************
	// levels pass two flops; the third copy gives the edge
	assign c_start  = c_q.scl_s && c_q.scl_p && c_q.sda_p && !c_q.sda_s;
	assign c_stop   = c_q.scl_s && c_q.scl_p && !c_q.sda_p && c_q.sda_s;
	assign commit_w = c_stop && !c_q.busy && (c_q.tog_s != c_q.tog_seen);

	always_comb begin
		c_d       = c_q;
		c_d.scl_m = scl_clk;
		c_d.scl_s = c_q.scl_m;
		c_d.scl_p = c_q.scl_s;
		c_d.sda_m = sda_i;
		c_d.sda_s = c_q.sda_m;
		c_d.sda_p = c_q.sda_s;
		c_d.tog_m = l_q.wr_tog;
		c_d.tog_s = c_q.tog_m;
		if (commit_w) begin
			// stop after new data: begin the timed write
			c_d.busy     = 1'b1;
			c_d.tog_seen = c_q.tog_s;
			c_d.timer    = TWE_TIMER_W'(WRITE_CYCLES - 1);
		end else if (c_q.busy) begin
			if (c_q.timer == '0) begin
				c_d.busy = 1'b0;
			end else begin
				c_d.timer = c_q.timer - 1'b1;
			end
		end
		// stop ends the frame in low power; start wakes it
		if (c_stop) begin
			c_d.standby = 1'b1;
		end else if (c_start) begin
			c_d.standby = 1'b0;
		end
	end

	// core state register
	always_ff @(posedge core_clk) begin
		if (reset) begin
			c_q         <= '0;
			c_q.scl_m   <= 1'b1;
			c_q.scl_s   <= 1'b1;
			c_q.scl_p   <= 1'b1;
			c_q.sda_m   <= 1'b1;
			c_q.sda_s   <= 1'b1;
			c_q.sda_p   <= 1'b1;
			c_q.standby <= 1'b1;
		end else begin
			c_q <= c_d;
		end
	end

	// array update at the end of the timed write; the page buffer
	// is frozen since the engine refuses the bus while busy
	always_ff @(posedge core_clk) begin
		if (c_q.busy && c_q.timer == '0) begin
			for (int i = 0; i < 4; i++) begin
				if (l_q.valid[i]) begin
					mem[{l_q.addr[6:2], 2'(i)}] <= l_q.page[i];
				end
			end
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign sda_o      = l_q.out;
	assign sda_oe     = l_q.oe;
	assign standby    = c_q.standby;
	assign write_busy = c_q.busy;

	// ************************************************************
	// assertions
	// ************************************************************
	address_ack_a: assert property (
		@(negedge scl_clk) disable iff (link_rst)
		(!start_w && !stop_w && l_q.state == TWE_SADDR &&
		 l_q.cnt == TWE_LAST_BIT && match_w && !l_q.busy_s)
		|=> l_q.oe && l_q.cnt == TWE_ACK_SLOT)
		else $error("matching address not acknowledged");

	busy_no_ack_a: assert property (
		@(negedge scl_clk) disable iff (link_rst)
		(!start_w && !stop_w && l_q.state == TWE_SADDR &&
		 l_q.cnt == TWE_LAST_BIT && l_q.busy_s)
		|=> !l_q.oe && l_q.state == TWE_IGNORE)
		else $error("acknowledge given while busy");

	mismatch_quiet_a: assert property (
		@(negedge scl_clk) disable iff (link_rst)
		(l_q.state == TWE_IGNORE && !start_w) |=> !l_q.oe)
		else $error("line driven after mismatch");

	start_restart_a: assert property (
		@(negedge scl_clk) disable iff (link_rst)
		start_w |=> l_q.state == TWE_SADDR && l_q.cnt == 4'h0 && !l_q.oe)
		else $error("start did not restart address reception");

	data_ack_a: assert property (
		@(negedge scl_clk) disable iff (link_rst)
		(!start_w && !stop_w && l_q.state == TWE_DATA &&
		 l_q.cnt == TWE_LAST_BIT)
		|=> l_q.oe ##1 !l_q.oe || l_q.state != TWE_DATA)
		else $error("data byte not acknowledged for one clock");

	page_wrap_a: assert property (
		@(negedge scl_clk) disable iff (link_rst)
		(!start_w && !stop_w && l_q.state == TWE_DATA &&
		 l_q.cnt == TWE_LAST_BIT)
		|=> l_q.addr[6:2] == $past(l_q.addr[6:2]) &&
		    l_q.addr[1:0] == $past(l_q.addr[1:0]) + 2'h1)
		else $error("page address did not step in page");

	read_release_a: assert property (
		@(negedge scl_clk) disable iff (link_rst)
		(!start_w && !stop_w && l_q.state == TWE_READ &&
		 l_q.cnt == TWE_LAST_BIT) |=> !l_q.oe)
		else $error("line not released for master acknowledge");

	nack_ends_a: assert property (
		@(negedge scl_clk) disable iff (link_rst)
		(!start_w && !stop_w && l_q.state == TWE_READ &&
		 l_q.cnt == TWE_ACK_SLOT && sda_hi_q)
		|=> l_q.state == TWE_IGNORE && !l_q.oe)
		else $error("output continued after no acknowledge");

	seq_count_a: assert property (
		@(negedge scl_clk) disable iff (link_rst)
		(!start_w && !stop_w && l_q.state == TWE_READ &&
		 l_q.cnt == TWE_ACK_SLOT && !sda_hi_q)
		|=> l_q.addr == $past(l_q.addr) + 7'h01)
		else $error("read counter did not advance");

	write_time_a: assert property (
		@(posedge core_clk) disable iff (reset)
		$rose(c_q.busy) |-> c_q.timer == TWE_TIMER_W'(WRITE_CYCLES - 1))
		else $error("write timer loaded with wrong count");

	write_end_a: assert property (
		@(posedge core_clk) disable iff (reset)
		(c_q.busy && c_q.timer == '0) |=> !c_q.busy)
		else $error("write did not end when timer ran out");

	stop_standby_a: assert property (
		@(posedge core_clk) disable iff (reset)
		c_stop |=> c_q.standby)
		else $error("stop did not enter standby");

endmodule // twe_slave

/* File: sim/twe_master_model.sv */
// bus master model: drives the serial clock and its share of data
// assumes: the bench resolves the open-drain data wire into sda_line
`timescale 1ns/1ps

module twe_master_model (
	// bus wires
	output logic      scl,
	output logic      sda_drv,
	input  wire logic sda_line
);
	// ************************************************************
	// bus phases, 80 ns bit period, clock idles high between frames
	// ************************************************************
	initial begin
		scl     = 1'b1;
		sda_drv = 1'b1;
	end

	// clock pulses with data released; they frame nothing and let the
	// reset crossing of the slave settle on either side of its release
	task automatic pulses(input int n);
		#3;
		for (int i = 0; i < n; i++) begin
			scl = 1'b0;
			#40 scl = 1'b1;
			#40;
		end
	endtask

	// also serves as a repeated start when the clock is low
	task automatic start();
		#7 sda_drv = 1'b1;
		if (scl) begin
			// clock fall with data high: the engine sees the stop
			// that ended the previous frame before this start
			#40 scl = 1'b0;
		end
		#40 scl = 1'b1;
		#40 sda_drv = 1'b0;
		#40 scl = 1'b0;
		#20;
	endtask

	// entered with the clock low and the line already released
	task automatic stop();
		#20 sda_drv = 1'b0;
		#40 scl = 1'b1;
		#40 sda_drv = 1'b1;
	endtask

	// eight bits msb first, then release and sample the acknowledge
	task automatic send(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			sda_drv = b[i];
			#20 scl = 1'b1;
			#40 scl = 1'b0;
			#20;
		end
		sda_drv = 1'b1;
		#20 scl = 1'b1;
		#20 ack = ~sda_line;
		#20 scl = 1'b0;
		#20;
	endtask

	// eight bits from the slave, then our acknowledge or its absence
	// entered with data already released by the slot before
	task automatic recv(input logic ack, output logic [7:0] b);
		for (int i = 0; i < 8; i++) begin
			#40 scl = 1'b1;
			#20 b = {b[6:0], sda_line};
			#20 scl = 1'b0;
		end
		#20 sda_drv = ~ack;
		#20 scl = 1'b1;
		#40 scl = 1'b0;
		#20 sda_drv = 1'b1;
	endtask
endmodule // twe_master_model

/* File: sim/test_two_wire_eeprom_slave_write.sv */
// self-checking bench for the two-wire serial memory slave
// assumes: twe_pkg and twe_slave compiled first, master model beside it
`timescale 1ns/1ps

module test_two_wire_eeprom_slave_write;
	import twe_pkg::*;
	// ************************************************************
	// set-up and wiring
	// ************************************************************
	localparam int         WCYC  = 200;  // shortened write time
	localparam logic [2:0] STRAP = 3'h5; // straps of this slave
	logic       core_clk;   // core clock
	logic       reset;      // core reset
	logic [2:0] strap;      // select strap levels
	wire        scl;        // serial clock from master
	wire        sda_drv;    // master share of data wire
	wire        sda_line;   // resolved data wire, pulled up
	logic       sda_o;      // slave data value
	logic       sda_oe;     // slave pulls low
	logic       standby;    // low-power state
	logic       write_busy; // internal write running
	int         mismatches; // failed comparisons
	int         cmp_count;  // comparisons made
	logic       ack;        // last acknowledge seen
	logic [7:0] rb;         // last byte read
	int         n;          // wait counter
	logic [7:0] pd [5] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55};

	// wired-and of both parties against the pull-up
	assign sda_line = sda_drv & ~(sda_oe & ~sda_o);

	twe_slave #(.WRITE_CYCLES(WCYC), .DEVICE_TYPE(TWE_TYPE_DEF)) DUT (
		.core_clk(core_clk), .reset(reset), .scl_clk(scl),
		.sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
		.select_strap_bit0(strap[0]), .select_strap_bit1(strap[1]),
		.select_strap_bit2(strap[2]), .standby(standby),
		.write_busy(write_busy));
	twe_master_model BFM (.scl(scl), .sda_drv(sda_drv), .sda_line(sda_line));

	// ************************************************************
	// helpers
	// ************************************************************
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	function automatic logic [7:0] sa(input logic rw);
		return {TWE_TYPE_DEF, STRAP, rw};
	endfunction
	task automatic cyc(input int k);
		repeat (k) @(posedge core_clk);
		#1;
	endtask
	task automatic check_bit(input logic e, input logic g);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %0t exp %h got %h", $time, e, g);
		end
	endtask
	task automatic check_byte(input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %0t exp %h got %h", $time, e, g);
		end
	endtask
	task automatic check_count(input int e, input int g);
		cmp_count++;
		if (g != e) begin
			mismatches++;
			$display("[FAIL] %0t exp %h got %h", $time, e, g);
		end
	endtask
	// bounded waits on the internal write flag
	task automatic wait_busy(input logic lvl, input int lim);
		for (n = 0; n < lim && write_busy !== lvl; n++) cyc(1);
	endtask

	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic t_reset();
		check_bit(1'b1, standby);
		check_bit(1'b0, write_busy);
		check_bit(1'b0, sda_oe);
	endtask
	// every wrong address bit is refused, and the next byte too
	task automatic t_mismatch();
		for (int i = 1; i < 8; i++) begin
			BFM.start();
			BFM.send(sa(1'b0) ^ (8'h01 << i), ack);
			check_bit(1'b0, ack);
			BFM.send(8'h00, ack);
			check_bit(1'b0, ack);
			BFM.stop();
		end
		// a strap change moves this slave away from the address
		@(posedge core_clk);
		strap <= STRAP ^ 3'h2;
		BFM.start();
		BFM.send(sa(1'b0), ack);
		check_bit(1'b0, ack);
		BFM.stop();
		@(posedge core_clk);
		strap <= STRAP;
	endtask
	// byte write to word 0, top address bit set and ignored
	task automatic t_byte_write();
		BFM.start();
		BFM.send(sa(1'b0), ack);
		check_bit(1'b1, ack);
		check_bit(1'b0, standby);
		BFM.send(8'h80, ack);
		check_bit(1'b1, ack);
		BFM.send(8'h3C, ack);
		check_bit(1'b1, ack);
		BFM.stop();
		wait_busy(1'b1, 20);
		check_bit(1'b1, write_busy);
		for (n = 0; n < 1000 && write_busy === 1'b1; n++) cyc(1);
		check_count(WCYC, n);
	endtask
	// five bytes into a four-byte page, polled while busy
	task automatic t_page_write();
		BFM.start();
		BFM.send(sa(1'b0), ack);
		BFM.send(8'h7E, ack);
		for (int i = 0; i < 5; i++) begin
			BFM.send(pd[i], ack);
			check_bit(1'b1, ack);
		end
		BFM.stop();
		wait_busy(1'b1, 20);
		BFM.start();
		BFM.send(sa(1'b0), ack);
		check_bit(1'b0, ack);
		BFM.stop();
		wait_busy(1'b0, 1000);
		cyc(5);
		BFM.start();
		BFM.send(sa(1'b0), ack);
		check_bit(1'b1, ack);
		BFM.stop();
	endtask
	// current address read crossing the top of memory
	task automatic t_current_read();
		BFM.start();
		BFM.send(sa(1'b1), ack);
		check_bit(1'b1, ack);
		BFM.recv(1'b1, rb);
		check_byte(pd[1], rb);
		BFM.recv(1'b0, rb);
		check_byte(8'h3C, rb);
		#40;
		check_bit(1'b0, sda_oe);
		BFM.stop();
		cyc(5);
		check_bit(1'b1, standby);
	endtask
	// dummy write, restart, then a sequential read of the page
	task automatic t_random_read();
		BFM.start();
		BFM.send(sa(1'b0), ack);
		BFM.send(8'h7C, ack);
		BFM.start();
		BFM.send(sa(1'b1), ack);
		check_bit(1'b1, ack);
		BFM.recv(1'b1, rb);
		check_byte(pd[2], rb);
		BFM.recv(1'b1, rb);
		check_byte(pd[3], rb);
		BFM.recv(1'b0, rb);
		check_byte(pd[4], rb);
		BFM.stop();
	endtask

	// ************************************************************
	// run control
	// ************************************************************
	task automatic end_sim();
		if (mismatches == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial BFM.pulses(3);
	initial begin
		reset      = 1'b1;
		strap      = STRAP;
		mismatches = 0;
		cmp_count  = 0;
		repeat (10) @(posedge core_clk);
		reset <= 1'b0;
		cyc(5);
		t_reset();
		// link reset leaves only after two clock falls past release
		BFM.pulses(2);
		t_mismatch();
		t_byte_write();
		t_page_write();
		t_current_read();
		t_random_read();
		end_sim();
	end
	// a hang counts as a mismatch
	initial begin
		#300000;
		mismatches++;
		end_sim();
	end
endmodule // test_two_wire_eeprom_slave_write
